// ---- pkg/axc_pkg.sv ----
package axc_pkg;

  // Register offsets on the device's serial register port
  localparam logic [7:0] AXC_OFS_CH1_TARGET = 8'h28;
  localparam logic [7:0] AXC_OFS_CH1_START = 8'h29;
  localparam logic [7:0] AXC_OFS_CH1_CONTROL = 8'h2A;
  localparam logic [7:0] AXC_OFS_CH2_TARGET = 8'h2B;
  localparam logic [7:0] AXC_OFS_CH2_START = 8'h2C;
  localparam logic [7:0] AXC_RESET_VAL = 8'h00;
  localparam logic [7:0] AXC_UNMAPPED_VAL = 8'h00;

  // Field positions within the target and control registers
  localparam int AXC_RNW_BIT = 7;
  localparam int AXC_EN_BIT = 7;
  localparam int AXC_SWAP_BIT = 6;
  localparam int AXC_SKIP_BIT = 5;
  localparam int AXC_GRP_BIT = 4;
  localparam int AXC_LEN_MSB = 3;

  typedef struct packed {
    logic ch1_read_not_write;
    logic [6:0] ch1_target_bus_addr;
  } axc_target_t;

  typedef struct packed {
    logic ch1_enable;
    logic ch1_byte_swap;
    logic ch1_skip_reg_write;
    logic ch1_group_align;
    logic [3:0] ch1_read_length;
  } axc_ctrl_t;

  // One byte bound for an external data slot
  localparam int AXC_SLOT_W = 5;
  localparam int AXC_FIFO_DEPTH = 16;
  typedef struct packed {
    logic [4:0] slot;
    logic [7:0] data;
  } axc_slot_word_t;

  // Aux bus timing: each bit is four quarter phases
  localparam int AXC_CLK_PERIOD_NS = 8;
  localparam int AXC_SCL_PERIOD_NS = 2500;
  localparam int AXC_QTR_CYCLES = AXC_SCL_PERIOD_NS / (4 * AXC_CLK_PERIOD_NS);
  localparam logic [1:0] AXC_Q_LAST = 2'h3;
  localparam logic [1:0] AXC_Q_SAMPLE = 2'h2;
  localparam logic [3:0] AXC_ACK_BIT = 4'h8;

  typedef enum logic [3:0] {
    AXC_IDLE,
    AXC_START,
    AXC_ADDR1,
    AXC_REG,
    AXC_RSTART,
    AXC_ADDR2,
    AXC_WAIT,
    AXC_DATA_R,
    AXC_DATA_W,
    AXC_STOP
  } axc_state_t;

endpackage

// ---- rtl/axc_channel_cfg.sv ----
`timescale 1ns/100ps
// How it works
// - Channel-one target holds read/write in bit 7, bus address in bits 6:0.
// - Channel-two target uses the same read/write and address layout.
// - Channel-one start register gives the slave register where transfers begin.
// - Channel-two start register gives the slave register where transfers begin; here it is only stored and read back, channel two never transfers.
// - Enabled channel one reads once per sample tick that arrives while it is idle, after channel zero's slots.
// - Disabled channel one does no periodic reads and stores nothing.
// - Byte swap on: both bytes of a word are stored swapped.
// - Unpaired first or last byte is stored unswapped.
// - Pairing follows slave register addresses, not destination slot positions.
// - Byte swap off: bytes stored in the order read.
// - Skip-register-write on: no register address phase, data only.
// - Grouping zero pairs addresses 0/1, 2/3; odd address closes a group.
// - Grouping one pairs addresses 1/2, 3/4; even address closes a group.
// - Four-bit length sets bytes read per sample period.
// - Channel zero starts at slot zero; channel one follows its bytes.

module axc_fifo
  import axc_pkg::*;
#(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  wire full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  wire empty = (wr_ptr_reg == rd_ptr_reg);
  wire do_wr = in_valid && !full;
  wire do_rd = out_ready && !empty;

  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (do_wr)
    begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (do_rd)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule

module axc_channel_cfg
  import axc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic sample_tick,
  input wire logic ch0_enable,
  input wire logic [3:0] ch0_read_length,
  input wire logic [7:0] ch1_write_data,
  output logic slot_valid,
  input wire logic slot_ready,
  output axc_slot_word_t slot_word,
  output logic ch1_busy,
  output logic aux_scl_out,
  output logic aux_scl_oe,
  input wire logic aux_sda_in,
  output logic aux_sda_out,
  output logic aux_sda_oe
);
  // Destination slot of the byte at index idx, with swap pairing by slave address
  function automatic logic [4:0] dest_slot(input logic [4:0] base, input logic [3:0] idx,
                                           input logic [3:0] len, input logic [7:0] start,
                                           input logic swap, input logic grp);
    logic addr_lsb;
    logic opener;
    logic [4:0] pos;
    addr_lsb = start[0] ^ idx[0];
    opener = (addr_lsb == grp);
    pos = base + {1'b0, idx};
    if (swap && opener && ({1'b0, idx} + 5'h01 < {1'b0, len}))
      dest_slot = pos + 5'h01;
    else if (swap && !opener && (idx != 4'h0))
      dest_slot = pos - 5'h01;
    else
      dest_slot = pos;
  endfunction

  axc_target_t ch1_target_reg;
  logic [7:0] ch1_start_reg_addr_reg;
  axc_ctrl_t ch1_ctrl_reg;
  axc_target_t ch2_target_reg;
  logic [7:0] ch2_start_reg_addr_reg;
  logic [7:0] reg_rdata_reg;

  axc_state_t state_reg;
  axc_target_t cur_tgt_reg;
  axc_ctrl_t cur_ctrl_reg;
  logic [7:0] cur_start_reg;
  logic [4:0] cur_base_reg;
  logic [7:0] cur_wdata_reg;
  logic [3:0] idx_reg;
  logic [1:0] q_reg;
  logic [3:0] bit_cnt_reg;
  logic [8:0] shift_reg;
  logic [7:0] rx_reg;
  logic nack_reg;
  logic [6:0] div_reg;
  logic tick_reg;
  logic sda_meta_reg;
  logic sda_sync_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  logic busy_reg;
  logic slot_valid_reg;
  axc_slot_word_t slot_word_reg;

  // Register port decode
  wire sel_t1 = (reg_addr == AXC_OFS_CH1_TARGET);
  wire sel_s1 = (reg_addr == AXC_OFS_CH1_START);
  wire sel_c1 = (reg_addr == AXC_OFS_CH1_CONTROL);
  wire sel_t2 = (reg_addr == AXC_OFS_CH2_TARGET);
  wire sel_s2 = (reg_addr == AXC_OFS_CH2_START);
  wire [7:0] rd_mux = sel_t1 ? ch1_target_reg :
                      sel_s1 ? ch1_start_reg_addr_reg :
                      sel_c1 ? ch1_ctrl_reg :
                      sel_t2 ? ch2_target_reg :
                      sel_s2 ? ch2_start_reg_addr_reg : AXC_UNMAPPED_VAL;

  // Sequencer decode
  wire active = (state_reg != AXC_IDLE) && (state_reg != AXC_WAIT);
  wire bit_end = tick_reg && (q_reg == AXC_Q_LAST);
  wire div_wrap = (div_reg == 7'(AXC_QTR_CYCLES - 1));
  wire byte_st = (state_reg == AXC_ADDR1) || (state_reg == AXC_REG) ||
                 (state_reg == AXC_ADDR2) || (state_reg == AXC_DATA_R) ||
                 (state_reg == AXC_DATA_W);
  wire byte_done = byte_st && bit_end && (bit_cnt_reg == AXC_ACK_BIT);
  wire last_byte = (idx_reg + 4'h1 == cur_ctrl_reg.ch1_read_length);
  wire first_rnw = cur_ctrl_reg.ch1_skip_reg_write && cur_tgt_reg.ch1_read_not_write;
  wire start_req = sample_tick && ch1_ctrl_reg.ch1_enable &&
                   (ch1_ctrl_reg.ch1_read_length != 4'h0 || !ch1_target_reg.ch1_read_not_write);
  wire [4:0] base_w = ch0_enable ? {1'b0, ch0_read_length} : 5'h00;
  wire fifo_in_ready;
  wire fifo_out_valid;
  axc_slot_word_t fifo_out_data;
  wire push = (state_reg == AXC_DATA_R) && byte_done && ch1_ctrl_reg.ch1_enable;
  axc_slot_word_t push_word;
  assign push_word.slot = dest_slot(cur_base_reg, idx_reg, cur_ctrl_reg.ch1_read_length,
                                    cur_start_reg, cur_ctrl_reg.ch1_byte_swap,
                                    cur_ctrl_reg.ch1_group_align);
  assign push_word.data = rx_reg;
  wire out_take = !slot_valid_reg || slot_ready;

  // Line drive levels per symbol phase
  wire st_start = (state_reg == AXC_START) || (state_reg == AXC_RSTART);
  wire scl_low_w = (state_reg == AXC_WAIT) ||
                   ((st_start || byte_st) && (q_reg == 2'h0 || q_reg == AXC_Q_LAST)) ||
                   ((state_reg == AXC_STOP) && (q_reg == 2'h0));
  wire sda_low_w = (st_start && q_reg[1]) ||
                   (byte_st && !shift_reg[8]) ||
                   ((state_reg == AXC_STOP) && !q_reg[1]);

  axc_fifo #(.WIDTH($bits(axc_slot_word_t)), .DEPTH(AXC_FIFO_DEPTH)) i_axc_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(fifo_out_valid),
    .out_ready(out_take),
    .out_data(fifo_out_data)
  );

  // Configuration registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ch1_target_reg <= AXC_RESET_VAL;
      ch1_start_reg_addr_reg <= AXC_RESET_VAL;
      ch1_ctrl_reg <= AXC_RESET_VAL;
      ch2_target_reg <= AXC_RESET_VAL;
      ch2_start_reg_addr_reg <= AXC_RESET_VAL;
      reg_rdata_reg <= AXC_RESET_VAL;
    end
    else
    begin
      if (reg_wr_en && sel_t1)
        ch1_target_reg <= reg_wdata;
      if (reg_wr_en && sel_s1)
        ch1_start_reg_addr_reg <= reg_wdata;
      if (reg_wr_en && sel_c1)
        ch1_ctrl_reg <= reg_wdata;
      if (reg_wr_en && sel_t2)
        ch2_target_reg <= reg_wdata;
      if (reg_wr_en && sel_s2)
        ch2_start_reg_addr_reg <= reg_wdata;
      if (reg_rd_en)
        reg_rdata_reg <= rd_mux;
    end
  end

  // Quarter-bit enable and line sampling
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_reg <= '0;
      tick_reg <= 1'b0;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= div_wrap;
      // Held at zero while idle so the first quarter of a frame is full length
      div_reg <= (div_wrap || state_reg == AXC_IDLE) ? 7'h00 : div_reg + 7'h01;
      sda_meta_reg <= aux_sda_in;
      sda_sync_reg <= sda_meta_reg;
      scl_oe_reg <= scl_low_w;
      sda_oe_reg <= sda_low_w;
      busy_reg <= (state_reg != AXC_IDLE);
    end
  end

  // Transfer sequencer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= AXC_IDLE;
      cur_tgt_reg <= AXC_RESET_VAL;
      cur_ctrl_reg <= AXC_RESET_VAL;
      cur_start_reg <= AXC_RESET_VAL;
      cur_base_reg <= '0;
      cur_wdata_reg <= AXC_RESET_VAL;
      idx_reg <= '0;
      q_reg <= '0;
      bit_cnt_reg <= '0;
      shift_reg <= '1;
      rx_reg <= '0;
      nack_reg <= 1'b0;
    end
    else
    begin
      if (tick_reg && active)
        q_reg <= q_reg + 2'h1;
      if (tick_reg && byte_st && (q_reg == AXC_Q_SAMPLE))
      begin
        if (bit_cnt_reg == AXC_ACK_BIT)
          nack_reg <= sda_sync_reg;
        else
          rx_reg <= {rx_reg[6:0], sda_sync_reg};
      end
      if (byte_st && bit_end)
      begin
        bit_cnt_reg <= (bit_cnt_reg == AXC_ACK_BIT) ? 4'h0 : bit_cnt_reg + 4'h1;
        shift_reg <= {shift_reg[7:0], 1'b1};
      end
      case (state_reg)
        AXC_IDLE:
          if (start_req)
          begin
            cur_tgt_reg <= ch1_target_reg;
            cur_ctrl_reg <= ch1_ctrl_reg;
            cur_start_reg <= ch1_start_reg_addr_reg;
            cur_base_reg <= base_w;
            cur_wdata_reg <= ch1_write_data;
            idx_reg <= '0;
            q_reg <= '0;
            state_reg <= AXC_START;
          end
        AXC_START:
          if (bit_end)
          begin
            shift_reg <= {cur_tgt_reg.ch1_target_bus_addr, first_rnw, 1'b1};
            state_reg <= AXC_ADDR1;
          end
        AXC_ADDR1:
          if (byte_done)
          begin
            if (nack_reg)
              state_reg <= AXC_STOP;
            else if (!cur_ctrl_reg.ch1_skip_reg_write)
            begin
              shift_reg <= {cur_start_reg, 1'b1};
              state_reg <= AXC_REG;
            end
            else if (cur_tgt_reg.ch1_read_not_write)
              state_reg <= AXC_WAIT;
            else
            begin
              shift_reg <= {cur_wdata_reg, 1'b1};
              state_reg <= AXC_DATA_W;
            end
          end
        AXC_REG:
          if (byte_done)
          begin
            if (nack_reg)
              state_reg <= AXC_STOP;
            else if (cur_tgt_reg.ch1_read_not_write)
              state_reg <= AXC_RSTART;
            else
            begin
              shift_reg <= {cur_wdata_reg, 1'b1};
              state_reg <= AXC_DATA_W;
            end
          end
        AXC_RSTART:
          if (bit_end)
          begin
            shift_reg <= {cur_tgt_reg.ch1_target_bus_addr, 1'b1, 1'b1};
            state_reg <= AXC_ADDR2;
          end
        AXC_ADDR2:
          if (byte_done)
            state_reg <= nack_reg ? AXC_STOP : AXC_WAIT;
        AXC_WAIT:
          if (fifo_in_ready)
          begin
            shift_reg <= {8'hFF, last_byte};
            state_reg <= AXC_DATA_R;
          end
        AXC_DATA_R:
          if (byte_done)
          begin
            idx_reg <= idx_reg + 4'h1;
            state_reg <= last_byte ? AXC_STOP : AXC_WAIT;
          end
        AXC_DATA_W:
          if (byte_done)
            state_reg <= AXC_STOP;
        AXC_STOP:
          if (bit_end)
            state_reg <= AXC_IDLE;
        default:
          state_reg <= AXC_IDLE;
      endcase
    end
  end

  // Registered slot output stage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      slot_valid_reg <= 1'b0;
      slot_word_reg <= '0;
    end
    else if (out_take)
    begin
      slot_valid_reg <= fifo_out_valid;
      slot_word_reg <= fifo_out_data;
    end
  end

  assign reg_rdata = reg_rdata_reg;
  assign slot_valid = slot_valid_reg;
  assign slot_word = slot_word_reg;
  assign ch1_busy = busy_reg;
  assign aux_scl_out = 1'b0;
  assign aux_sda_out = 1'b0;
  assign aux_scl_oe = scl_oe_reg;
  assign aux_sda_oe = sda_oe_reg;
endmodule

// ---- sim/axc_checker_sva.sv ----
`timescale 1ns/100ps
module axc_checker
  import axc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic sample_tick,
  input wire logic slot_valid,
  input wire logic slot_ready,
  input wire axc_slot_word_t slot_word,
  input wire logic ch1_busy,
  input wire logic aux_scl_oe,
  input wire logic aux_sda_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] ctl_reg;
  logic [7:0] tgt_reg;
  logic [7:0] gap_reg;
  wire mapped = reg_addr >= AXC_OFS_CH1_TARGET && reg_addr <= AXC_OFS_CH2_START;
  wire can_go = ctl_reg[AXC_EN_BIT] && (ctl_reg[3:0] != 4'h0 || !tgt_reg[AXC_RNW_BIT]);
  // Shadow of the channel-one config
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      ctl_reg <= 8'h00;
      tgt_reg <= 8'h00;
    end
    else if (reg_wr_en && reg_addr == AXC_OFS_CH1_CONTROL)
      ctl_reg <= reg_wdata;
    else if (reg_wr_en && reg_addr == AXC_OFS_CH1_TARGET)
      tgt_reg <= reg_wdata;
  // Cycles since the clock line last moved
  always_ff @(posedge clk or posedge rst)
    if (rst)
      gap_reg <= 8'hFF;
    else if ($changed(aux_scl_oe))
      gap_reg <= 8'h00;
    else if (gap_reg != 8'hFF)
      gap_reg <= gap_reg + 8'h01;
  a_rd_unmapped: assert property (reg_rd_en && !mapped |=> reg_rdata == AXC_UNMAPPED_VAL)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_rd_en |=> $stable(reg_rdata))
    else $error("read data moved without read");
  a_write_readback: assert property (
    reg_wr_en && mapped ##1 !reg_wr_en && !reg_rd_en
    ##1 reg_rd_en && !reg_wr_en && $past(reg_addr, 2) == reg_addr
    |=> reg_rdata == $past(reg_wdata, 3))
    else $error("register readback wrong");
  a_slot_stall: assert property (slot_valid && !slot_ready |=> slot_valid && $stable(slot_word))
    else $error("slot word dropped while stalled");
  a_off_stays_idle: assert property (
    !ctl_reg[AXC_EN_BIT] && !ch1_busy && !$past(sample_tick) |=> !ch1_busy)
    else $error("transfer while disabled");
  a_tick_starts: assert property (
    sample_tick && !ch1_busy && !$past(ch1_busy) && can_go |-> ##[1:2] ch1_busy)
    else $error("tick did not start transfer");
  a_lines_freed: assert property ($fell(ch1_busy) |-> ##[0:2] (!aux_scl_oe && !aux_sda_oe))
    else $error("bus lines held after transfer");
  a_scl_spacing: assert property ($changed(aux_scl_oe) |-> gap_reg >= 8'(AXC_QTR_CYCLES - 1))
    else $error("clock line moved too soon");
endmodule

bind axc_channel_cfg axc_checker i_axc_checker (.clk, .rst, .reg_wr_en, .reg_rd_en,
  .reg_addr, .reg_wdata, .reg_rdata, .sample_tick, .slot_valid, .slot_ready, .slot_word,
  .ch1_busy, .aux_scl_oe, .aux_sda_oe);

// ---- sim/axc_slave_model.sv ----
`timescale 1ns/100ps
module axc_slave_model
#(
  parameter logic [6:0] BUS_ADDR = 7'h1D
)
(
  input wire logic scl,
  input wire logic sda,
  output logic sda_pull
);
  int bitn = 0;
  logic [7:0] sh;
  logic [7:0] tx;
  logic [7:0] ptr = 8'h00;
  logic [7:0] wlast = 8'h00;
  logic first = 1'b0;
  logic hit = 1'b0;
  logic rd = 1'b0;
  logic regd = 1'b0;
  logic done = 1'b1;
  initial
    sda_pull = 1'b0;
  // Start or repeated start
  always @(negedge sda)
    if (scl)
    begin
      bitn = 0;
      first = 1'b1;
      rd = 1'b0;
      regd = 1'b0;
      done = 1'b0;
    end
  always @(posedge sda)
    if (scl)
      hit = 1'b0;
  always @(posedge scl)
    if (bitn < 8)
    begin
      sh = {sh[6:0], sda};
      bitn = bitn + 1;
    end
    else
    begin
      if (rd && sda)
        done = 1'b1;
      bitn = 0;
    end
  // Acks and read data change only while the clock is low
  always @(negedge scl)
  begin
    sda_pull = 1'b0;
    if (bitn == 8 && (first || !rd))
    begin
      if (first)
      begin
        hit = sh[7:1] == BUS_ADDR;
        rd = sh[0];
        first = 1'b0;
        sda_pull = hit;
      end
      else if (hit)
      begin
        if (regd)
          wlast = sh;
        else
          ptr = sh;
        regd = 1'b1;
        sda_pull = 1'b1;
      end
    end
    else if (hit && rd && !done && bitn < 8)
    begin
      tx = ptr ^ 8'h5A;
      sda_pull = !tx[7 - bitn];
      if (bitn == 7)
        ptr = ptr + 8'h01;
    end
  end
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/100ps
module tb
  import axc_pkg::*;
();
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic sample_tick = 1'b0;
  logic ch0_enable = 1'b0;
  logic [3:0] ch0_read_length = 4'h0;
  logic [7:0] ch1_write_data = 8'h00;
  logic slot_valid;
  logic slot_ready = 1'b0;
  axc_slot_word_t slot_word;
  logic ch1_busy;
  logic aux_scl_out;
  logic aux_scl_oe;
  logic aux_sda_out;
  logic aux_sda_oe;
  logic pull;
  int bad_count = 0;
  int checks = 0;
  wire logic scl = !aux_scl_oe;
  wire logic aux_sda_in = !(aux_sda_oe || pull);
  axc_channel_cfg i_axc_channel_cfg (
    .clk(clk),
    .rst(rst),
    .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .sample_tick(sample_tick),
    .ch0_enable(ch0_enable),
    .ch0_read_length(ch0_read_length),
    .ch1_write_data(ch1_write_data),
    .slot_valid(slot_valid),
    .slot_ready(slot_ready),
    .slot_word(slot_word),
    .ch1_busy(ch1_busy),
    .aux_scl_out(aux_scl_out),
    .aux_scl_oe(aux_scl_oe),
    .aux_sda_in(aux_sda_in),
    .aux_sda_out(aux_sda_out),
    .aux_sda_oe(aux_sda_oe)
  );
  axc_slave_model i_axc_slave_model (.scl(scl), .sda(aux_sda_in), .sda_pull(pull));
  always #4 clk = !clk;
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk);
    reg_wr_en = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clk);
    reg_rd_en = 1'b0;
    chk(13'(reg_rdata), 13'(e));
    @(negedge clk);
  endtask
  task automatic tick;
    sample_tick = 1'b1;
    @(negedge clk);
    sample_tick = 1'b0;
  endtask
  // Tick twice, stall the consumer, then drain and compare every slot
  task automatic run(input int n, input logic [7:0] st, input logic [4:0] b, input logic sw,
    input logic g);
    logic [7:0] a;
    logic [4:0] s;
    tick();
    repeat (20) @(negedge clk);
    tick();
    for (int k = 0; k < 40000 && ch1_busy !== 1'b0; k++)
      @(negedge clk);
    slot_ready = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      a = st + 8'(i);
      s = b + 5'(i);
      if (sw && a[0] == g && i + 1 < n)
        s = s + 5'h01;
      else if (sw && a[0] != g && i > 0)
        s = s - 5'h01;
      chk(13'(slot_valid), 13'h0001);
      chk(slot_word, {s, a ^ 8'h5A});
      @(negedge clk);
    end
    chk(13'(slot_valid), 13'h0000);
    slot_ready = 1'b0;
  endtask
  task automatic t_regs;
    for (int i = 0; i < 5; i++)
      rd(AXC_OFS_CH1_TARGET + 8'(i), AXC_RESET_VAL);
    for (int i = 0; i < 5; i++)
    begin
      wr(AXC_OFS_CH1_TARGET + 8'(i), 8'h35 ^ 8'(i));
      rd(AXC_OFS_CH1_TARGET + 8'(i), 8'h35 ^ 8'(i));
    end
    wr(8'h30, 8'hFF);
    rd(8'h30, AXC_UNMAPPED_VAL);
  endtask
  task automatic t_swap;
    ch0_enable = 1'b1;
    ch0_read_length = 4'h3;
    wr(AXC_OFS_CH1_TARGET, 8'h9D);
    wr(AXC_OFS_CH1_START, 8'h01);
    wr(AXC_OFS_CH1_CONTROL, 8'hC4);
    run(4, 8'h01, 5'h03, 1'b1, 1'b0);
  endtask
  task automatic t_group_one;
    ch0_enable = 1'b0;
    wr(AXC_OFS_CH1_START, 8'h02);
    wr(AXC_OFS_CH1_CONTROL, 8'hD3);
    run(3, 8'h02, 5'h00, 1'b1, 1'b1);
  endtask
  task automatic t_skip_reg;
    wr(AXC_OFS_CH1_CONTROL, 8'hA2);
    run(2, 8'h05, 5'h00, 1'b0, 1'b0);
  endtask
  task automatic t_write;
    ch1_write_data = 8'hC3;
    wr(AXC_OFS_CH1_TARGET, 8'h1D);
    wr(AXC_OFS_CH1_START, 8'h40);
    wr(AXC_OFS_CH1_CONTROL, 8'h80);
    run(0, 8'h00, 5'h00, 1'b0, 1'b0);
    chk(13'(i_axc_slave_model.wlast), 13'h00C3);
    chk(13'(i_axc_slave_model.ptr), 13'h0040);
  endtask
  task automatic t_off;
    wr(AXC_OFS_CH1_TARGET, 8'h9D);
    wr(AXC_OFS_CH1_CONTROL, 8'h44);
    run(0, 8'h00, 5'h00, 1'b0, 1'b0);
    tick();
    repeat (3) @(negedge clk);
    chk(13'(ch1_busy), 13'h0000);
    chk(13'({aux_scl_out, aux_sda_out, aux_scl_oe, aux_sda_oe}), 13'h0000);
  endtask
  task automatic stop_test;
    $display("mismatches %0d checks %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #700000;
    bad_count++;
    stop_test();
  end
  initial
  begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_regs();
    t_swap();
    t_group_one();
    t_skip_reg();
    t_write();
    t_off();
    stop_test();
  end
endmodule
